/* logic/wtcr_pkg.sv */
/*
  constants, field layout, reset values and decode tables for the wake, pull,
  transceiver-rate and cyclic-timer configuration registers.
  assumes a 40 MHz system clock and a 16-bit serial frame framed by the chip select.
*/
// What this block does
// - sensing selected, no fail: ignore wake enable
// - fail active: reject sense set, flag
// - sensing: measure in normal, levels held zero
// - fail-safe entry without sensing forces x0x0_0001
// - fail-safe entry with sensing: no pin wake
// - bits 7:6 general io pull, wake-input only
// - bits 1:0 select wake pin pull
// - reserved bits read zero
// - bit 4 disables slew control for speed
// - on-time codes 001..101 decode
// - code 110 stops with output high
// - period codes 10ms up to seconds
// - timer starts once running on-time written
// - restart clearing switch also clears timer
// - cyclic wake and sense share timer
// - new timer setting active at select rise
// - internal bit 6 enables timer wake
package wtcr_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] OFS_INT_WAKE = 7'h06;
  localparam logic [6:0] OFS_EXT_WAKE = 7'h07;
  localparam logic [6:0] OFS_PULL = 7'h08;
  localparam logic [6:0] OFS_BUS_RATE = 7'h0B;
  localparam logic [6:0] OFS_TIMER = 7'h0C;
  localparam logic [6:0] OFS_STATUS = 7'h7E;
  localparam int BIT_CYCLE_WAKE = 6;
  localparam int BIT_GLOBAL_INT = 7;
  localparam int BIT_SENSE_SEL = 5;
  localparam int BIT_PIN_EN = 0;
  localparam int BIT_RATE = 4;
  localparam int POS_IO_PULL = 6;
  localparam int POS_PIN_PULL = 0;
  localparam int POS_ON = 4;
  localparam int POS_PER = 0;
  localparam logic [7:0] MASK_INT_WAKE = 8'h40;
  localparam logic [7:0] MASK_EXT_WAKE = 8'hA1;
  localparam logic [7:0] MASK_PULL = 8'hC3;
  localparam logic [7:0] MASK_BUS_RATE = 8'h10;
  localparam logic [7:0] MASK_TIMER = 8'h7F;
  localparam logic [7:0] RST_INT_WAKE = 8'h00;
  localparam logic [7:0] RST_EXT_WAKE = 8'h01;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_BUS_RATE = 8'h00;
  localparam logic [7:0] RST_TIMER = 8'h00;
  localparam logic [7:0] FAILSAFE_EXT_WAKE = 8'h01;
  localparam logic [2:0] ON_LOW = 3'h0;
  localparam logic [2:0] ON_HIGH = 3'h6;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 100000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    WTCR_IDLE = 2'b00,
    WTCR_SHIFT = 2'b01,
    WTCR_DONE = 2'b11
  } wtcr_spi_state_t;

  // on-time in 0.1 ms ticks, zero for the stopped codes
  function automatic logic [CNT_W-1:0] wtcr_on_ticks(input logic [2:0] code);
    case (code)
      3'h1: wtcr_on_ticks = 24'h000001;
      3'h2: wtcr_on_ticks = 24'h000003;
      3'h3: wtcr_on_ticks = 24'h00000A;
      3'h4: wtcr_on_ticks = 24'h000064;
      3'h5: wtcr_on_ticks = 24'h0000C8;
      default: wtcr_on_ticks = 24'h000000;
    endcase
  endfunction : wtcr_on_ticks

  // period in 0.1 ms ticks
  function automatic logic [CNT_W-1:0] wtcr_per_ticks(input logic [3:0] code);
    case (code)
      4'h0: wtcr_per_ticks = 24'h000064;
      4'h1: wtcr_per_ticks = 24'h0000C8;
      4'h2: wtcr_per_ticks = 24'h0001F4;
      4'h3: wtcr_per_ticks = 24'h0003E8;
      4'h4: wtcr_per_ticks = 24'h0007D0;
      4'h5: wtcr_per_ticks = 24'h001388;
      4'h6: wtcr_per_ticks = 24'h002710;
      4'h7: wtcr_per_ticks = 24'h004E20;
      4'h8: wtcr_per_ticks = 24'h00C350;
      4'h9: wtcr_per_ticks = 24'h0186A0;
      4'hA: wtcr_per_ticks = 24'h030D40;
      4'hB: wtcr_per_ticks = 24'h07A120;
      4'hC: wtcr_per_ticks = 24'h0F4240;
      4'hD: wtcr_per_ticks = 24'h1E8480;
      4'hE: wtcr_per_ticks = 24'h4C4B40;
      default: wtcr_per_ticks = 24'h989680;
    endcase
  endfunction : wtcr_per_ticks
endpackage : wtcr_pkg

/* logic/wtcr_regs.sv */
/*
  serial-port register bank for wake sensing, pull selection, transceiver rate and
  the cyclic timer, with the timer itself.
  assumes serial clock, select and data inputs synchronous to clk_sys_i (mode 0,
  msb first), and status inputs from the device's mode controller.
*/
`timescale 1ns/10ps
module wtcr_regs #(
  parameter int TICK_CYC = wtcr_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_n_i, // synchronous reset, active low
  input wire logic soft_reset_i, // soft reset pulse
  input wire logic serial_clk_i, // serial clock
  input wire logic serial_select_n_i, // chip select, active low
  input wire logic serial_mosi_i, // serial data in
  output logic serial_miso_o, // serial data out
  output logic serial_miso_oe_o, // serial data out enable
  input wire logic fail_output_active_i, // fail output active
  input wire logic fail_safe_entry_i, // pulse: fail-safe entered on failure
  input wire logic restart_clear_i, // pulse: restart cleared switch under cyclic sense
  input wire logic cyclic_sense_active_i, // cyclic sense in use
  input wire logic gpio_wake_cfg_i, // general io set up as wake input
  input wire logic normal_mode_i, // device in normal mode
  input wire logic wake_pin_level_i, // raw wake pin level
  input wire logic general_io_level_i, // raw general io level
  output logic wake_pin_level_o, // wake level status
  output logic general_io_level_o, // general io level status
  output logic measure_enable_o, // voltage measurement on
  output logic wake_pin_wake_src_o, // wake pin acts as wake source
  output logic gpio_cfg_ignored_o, // general io config ignored
  output logic [1:0] wake_pull_select_field_o, // wake pin pull
  output logic [1:0] general_io_pull_select_o, // general io pull
  output logic slew_control_off_o, // fast rate, no slew control
  output logic high_side_output_o, // timer driven switch output
  output logic timer_running_o, // timer counting
  output logic cycle_wake_o, // pulse: cyclic wake event
  output logic cycle_sense_o // pulse: cyclic sense sample
);
  import wtcr_pkg::*;

  // the tick counter is 16 bits wide and a tick must last at least two clocks
  if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_tick_check
    $error("tick count out of range");
  end

  wtcr_spi_state_t state_r, state_nxt;
  logic sck_q_r, sel_q_r, miso_r, spi_fail_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_in_r;
  logic [6:0] addr_hold_r;
  logic [7:0] status_snap_r;
  logic [7:0] int_wake_r, ext_wake_r, pull_r, bus_rate_r, timer_r;
  logic [15:0] tick_cnt_r;
  logic [CNT_W-1:0] cyc_cnt_r;
  logic hs_r, cyc_event_r, timer_load_r;

  wire sel = ~serial_select_n_i;
  wire frame_start = sel & ~sel_q_r;
  wire frame_end = ~sel & sel_q_r;
  wire sck_rise = sel & serial_clk_i & ~sck_q_r;
  wire sck_fall = sel & ~serial_clk_i & sck_q_r;
  wire frame_ok = frame_end && (bit_cnt_r == 5'(FRAME_BITS));
  wire frame_bad = frame_end && (bit_cnt_r != 5'(FRAME_BITS));
  wire wr_en = frame_ok & shift_in_r[15];
  wire [6:0] acc_addr = shift_in_r[14:8];
  wire [7:0] wr_data = shift_in_r[7:0];
  // address held from the eighth rise, the shift register moves on under the data byte
  wire [6:0] rd_addr = addr_hold_r;
  wire sense_sel = ext_wake_r[BIT_SENSE_SEL];
  wire [2:0] on_code = timer_r[POS_ON+:3];
  wire [3:0] per_code = timer_r[POS_PER+:4];
  wire on_valid = (on_code != ON_LOW) && (on_code <= 3'h5);
  wire [CNT_W-1:0] on_ticks = wtcr_on_ticks(on_code);
  wire [CNT_W-1:0] per_ticks = wtcr_per_ticks(per_code);
  wire tick = (tick_cnt_r == 16'(TICK_CYC - 1));
  wire per_end = tick && (cyc_cnt_r == per_ticks - 24'h000001);
  wire sense_set_rej = wr_en && (acc_addr == OFS_EXT_WAKE) && wr_data[BIT_SENSE_SEL] && fail_output_active_i;
  wire status_clr = frame_ok && !shift_in_r[15] && (acc_addr == OFS_STATUS);
  wire timer_wr = wr_en && (acc_addr == OFS_TIMER);

  // read decode shared by the shift-out path
  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] iw, input logic [7:0] ew,
                                        input logic [7:0] pu, input logic [7:0] br, input logic [7:0] tm,
                                        input logic [7:0] st);
    case (a)
      OFS_INT_WAKE: rd_mux = iw & MASK_INT_WAKE;
      OFS_EXT_WAKE: rd_mux = ew & MASK_EXT_WAKE;
      OFS_PULL: rd_mux = pu & MASK_PULL;
      OFS_BUS_RATE: rd_mux = br & MASK_BUS_RATE;
      OFS_TIMER: rd_mux = tm & MASK_TIMER;
      OFS_STATUS: rd_mux = st;
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  wire [7:0] status_now = {7'h00, spi_fail_r};
  wire [7:0] rd_data = rd_mux(rd_addr, int_wake_r, ext_wake_r, pull_r, bus_rate_r, timer_r, status_now);
  wire [15:0] out_word = {status_snap_r, (bit_cnt_r >= 5'h08) ? rd_data : 8'h00};
  wire [3:0] out_idx = 4'(5'h0F - bit_cnt_r);

  // frame sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      WTCR_IDLE: if (frame_start) begin
        state_nxt = WTCR_SHIFT;
      end
      WTCR_SHIFT: if (frame_end) begin
        state_nxt = WTCR_DONE;
      end
      WTCR_DONE: state_nxt = sel ? WTCR_SHIFT : WTCR_IDLE;
      default: state_nxt = WTCR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_r <= WTCR_IDLE;
      sck_q_r <= 1'b0;
      sel_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sck_q_r <= serial_clk_i;
      sel_q_r <= sel;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bit_cnt_r <= 5'h00;
      shift_in_r <= 16'h0000;
      addr_hold_r <= 7'h00;
      status_snap_r <= 8'h00;
      miso_r <= 1'b0;
    end else if (frame_start) begin
      bit_cnt_r <= 5'h00;
      status_snap_r <= status_now;
      miso_r <= status_now[7];
    end else if (sck_rise) begin
      shift_in_r <= {shift_in_r[14:0], serial_mosi_i};
      if (bit_cnt_r == 5'h07) begin
        addr_hold_r <= {shift_in_r[5:0], serial_mosi_i};
      end
      bit_cnt_r <= (bit_cnt_r == 5'h1F) ? bit_cnt_r : bit_cnt_r + 5'h01;
    end else if (sck_fall && bit_cnt_r < 5'(FRAME_BITS)) begin
      miso_r <= out_word[out_idx];
    end
  end

  // failure flag: set wins over the clearing read
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || soft_reset_i) begin
      spi_fail_r <= 1'b0;
    end else if (frame_bad || sense_set_rej) begin
      spi_fail_r <= 1'b1;
    end else if (status_clr) begin
      spi_fail_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || soft_reset_i) begin
      int_wake_r <= RST_INT_WAKE;
      pull_r <= RST_PULL;
      bus_rate_r <= RST_BUS_RATE;
    end else if (wr_en) begin
      if (acc_addr == OFS_INT_WAKE) begin
        int_wake_r <= wr_data & MASK_INT_WAKE;
      end
      if (acc_addr == OFS_PULL) begin
        pull_r <= wr_data & MASK_PULL;
      end
      if (acc_addr == OFS_BUS_RATE) begin
        bus_rate_r <= wr_data & MASK_BUS_RATE;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || soft_reset_i) begin
      ext_wake_r <= RST_EXT_WAKE;
    end else if (fail_safe_entry_i && !sense_sel) begin
      ext_wake_r <= (ext_wake_r & 8'hA0) | FAILSAFE_EXT_WAKE;
    end else if (wr_en && acc_addr == OFS_EXT_WAKE) begin
      ext_wake_r <= wr_data & MASK_EXT_WAKE & ~(fail_output_active_i ? 8'h20 : 8'h00);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || soft_reset_i) begin
      timer_r <= RST_TIMER;
      timer_load_r <= 1'b0;
    end else begin
      timer_load_r <= timer_wr || restart_clear_i;
      if (restart_clear_i) begin
        timer_r <= RST_TIMER;
      end else if (timer_wr) begin
        timer_r <= wr_data & MASK_TIMER;
      end
    end
  end

  // cyclic timer in 0.1 ms ticks, reloaded whenever a setting commits
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || soft_reset_i || timer_load_r || !on_valid) begin
      tick_cnt_r <= 16'h0000;
      cyc_cnt_r <= '0;
      cyc_event_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      cyc_event_r <= per_end;
      if (per_end) begin
        cyc_cnt_r <= '0;
      end else if (tick) begin
        cyc_cnt_r <= cyc_cnt_r + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      hs_r <= 1'b0;
    end else if (on_valid && !timer_load_r) begin
      hs_r <= (cyc_cnt_r < on_ticks);
    end else begin
      hs_r <= (on_code == ON_HIGH);
    end
  end

  assign serial_miso_o = miso_r;
  assign serial_miso_oe_o = sel;
  assign gpio_cfg_ignored_o = sense_sel & ~fail_output_active_i;
  assign wake_pin_wake_src_o = ext_wake_r[BIT_PIN_EN] & ~sense_sel;
  assign measure_enable_o = sense_sel & normal_mode_i;
  assign wake_pin_level_o = wake_pin_level_i & ~sense_sel;
  assign general_io_level_o = general_io_level_i & ~sense_sel;
  assign wake_pull_select_field_o = pull_r[POS_PIN_PULL+:2];
  assign general_io_pull_select_o = gpio_wake_cfg_i ? pull_r[POS_IO_PULL+:2] : 2'h0;
  assign slew_control_off_o = bus_rate_r[BIT_RATE];
  assign high_side_output_o = hs_r;
  assign timer_running_o = on_valid;
  assign cycle_wake_o = cyc_event_r & int_wake_r[BIT_CYCLE_WAKE];
  assign cycle_sense_o = cyc_event_r & cyclic_sense_active_i;

  property p_sense_reject;
    @(posedge clk_sys_i) disable iff (!reset_n_i || soft_reset_i)
      sense_set_rej && !fail_safe_entry_i |=> !ext_wake_r[BIT_SENSE_SEL] && spi_fail_r;
  endproperty
  a_sense_reject: assert property (p_sense_reject) else $error("sense bit set while fail active");

  property p_failsafe_force;
    @(posedge clk_sys_i) disable iff (!reset_n_i || soft_reset_i)
      fail_safe_entry_i && !sense_sel |=> ext_wake_r[6:0] == 7'h01;
  endproperty
  a_failsafe_force: assert property (p_failsafe_force) else $error("fail-safe wake pattern wrong");

  property p_failsafe_sense;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      sense_sel |-> !wake_pin_wake_src_o && !wake_pin_level_o && !general_io_level_o;
  endproperty
  a_failsafe_sense: assert property (p_failsafe_sense) else $error("pin wake while sensing");

  property p_measure;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      measure_enable_o == (ext_wake_r[BIT_SENSE_SEL] && normal_mode_i);
  endproperty
  a_measure: assert property (p_measure) else $error("measure enable mismatch");

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (pull_r[5:2] == 4'h0) && (bus_rate_r[7:5] == 3'h0) && (bus_rate_r[3:0] == 4'h0) && !timer_r[7];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored");

  property p_restart_clear;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      restart_clear_i |=> timer_r == 8'h00 && !timer_running_o;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("timer kept over restart");

  property p_commit;
    @(posedge clk_sys_i) disable iff (!reset_n_i || soft_reset_i || restart_clear_i)
      timer_wr |=> (timer_r == (wr_data & MASK_TIMER)) ##1 (cyc_cnt_r == '0);
  endproperty
  a_commit: assert property (p_commit) else $error("timer write not taken at select rise");

  property p_high_stop;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (on_code == ON_HIGH) [*2] |-> high_side_output_o;
  endproperty
  a_high_stop: assert property (p_high_stop) else $error("stopped-high output low");

  property p_low_stop;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      (on_code == ON_LOW) [*2] |-> !high_side_output_o && !cycle_wake_o;
  endproperty
  a_low_stop: assert property (p_low_stop) else $error("stopped-low timer active");

  property p_shared_event;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      cycle_wake_o && cyclic_sense_active_i |-> cycle_sense_o;
  endproperty
  a_shared_event: assert property (p_shared_event) else $error("wake and sense diverge");

  property p_slew;
    @(posedge clk_sys_i) disable iff (!reset_n_i || soft_reset_i)
      wr_en && acc_addr == OFS_BUS_RATE |=> slew_control_off_o == $past(wr_data[BIT_RATE]);
  endproperty
  a_slew: assert property (p_slew) else $error("rate bit not written");

  property p_rate_hold;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      !(wr_en && acc_addr == OFS_BUS_RATE) && !soft_reset_i |=> $stable(slew_control_off_o);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate bit changed without write");

  property p_pull_write;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      wr_en && acc_addr == OFS_PULL && !soft_reset_i |=>
        wake_pull_select_field_o == $past(wr_data[POS_PIN_PULL+:2]);
  endproperty
  a_pull_write: assert property (p_pull_write) else $error("wake pull field not written");

  property p_io_pull;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      !gpio_wake_cfg_i |-> general_io_pull_select_o == 2'h0;
  endproperty
  a_io_pull: assert property (p_io_pull) else $error("general io pull applied outside wake use");

  property p_timer_start;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      timer_wr && !restart_clear_i && !soft_reset_i |=>
        timer_running_o == ($past(wr_data[POS_ON+:3]) inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5});
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("timer start does not follow on-time");

  property p_period_wrap;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      per_end && on_valid && !timer_load_r && !soft_reset_i |=> cyc_event_r && (cyc_cnt_r == '0);
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period end not taken");

  property p_sense_keep;
    @(posedge clk_sys_i) disable iff (!reset_n_i)
      fail_safe_entry_i && sense_sel && !wr_en && !soft_reset_i |=> $stable(ext_wake_r);
  endproperty
  a_sense_keep: assert property (p_sense_keep) else $error("wake control forced while sensing");
endmodule : wtcr_regs

/* tb/wtcr_host.sv */
/*
  serial host model: sends one frame of up to 16 bits, msb first, clock idle low.
  assumes the register bank samples the serial lines on clk_sys_i.
*/
`timescale 1ns/10ps
module wtcr_host (
  input wire logic clk_sys_i, // system clock
  input wire logic serial_miso_i, // data from the device
  output logic serial_clk_o, // serial clock
  output logic serial_select_n_o, // chip select, active low
  output logic serial_mosi_o // data to the device
);
  initial begin
    serial_clk_o = 1'h0;
    serial_select_n_o = 1'h1;
    serial_mosi_o = 1'h0;
  end

  // half periods of 4 clocks; data changes on the clock fall, sampled before the rise
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_sys_i);
    serial_select_n_o <= 1'h0;
    for (int i = 0; i < nbits; i++) begin
      serial_mosi_o <= tx[15 - i];
      repeat (4) @(posedge clk_sys_i);
      rx[15 - i] = serial_miso_i;
      serial_clk_o <= 1'h1;
      repeat (4) @(posedge clk_sys_i);
      serial_clk_o <= 1'h0;
    end
    repeat (2) @(posedge clk_sys_i);
    serial_select_n_o <= 1'h1;
    // a released data line shows the inverse of its last bit
    serial_mosi_o <= ~serial_mosi_o;
    repeat (4) @(posedge clk_sys_i);
  endtask : xfer
endmodule : wtcr_host

/* tb/wtcr_regs_tb.sv */
/*
  self-checking bench for the wake, pull, rate and timer register bank.
  assumes the serial host model and a timer tick shortened to 4 clocks.
*/
`timescale 1ns/10ps
module wtcr_regs_tb;
  import wtcr_pkg::*;
  localparam int TK = 4;
  logic clk_sys_i, reset_n_i, srst, sclk, serial_select_n, mosi, miso, oe;
  logic fo, fse, rcl, csa, gwk, nrm, wkl, iol;
  logic wklo, iolo, meas, src, ign, slew, hs, run, cwk, csen;
  logic [1:0] wkp, iop;
  logic [15:0] rx;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int on_tk[6] = '{0, 1, 3, 10, 100, 200};

  initial begin
    clk_sys_i = 1'h0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  wtcr_regs #(.TICK_CYC(TK)) u_wtcr_regs (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .soft_reset_i(srst),
    .serial_clk_i(sclk), .serial_select_n_i(serial_select_n), .serial_mosi_i(mosi),
    .serial_miso_o(miso), .serial_miso_oe_o(oe), .fail_output_active_i(fo),
    .fail_safe_entry_i(fse), .restart_clear_i(rcl), .cyclic_sense_active_i(csa),
    .gpio_wake_cfg_i(gwk), .normal_mode_i(nrm), .wake_pin_level_i(wkl),
    .general_io_level_i(iol), .wake_pin_level_o(wklo), .general_io_level_o(iolo),
    .measure_enable_o(meas), .wake_pin_wake_src_o(src), .gpio_cfg_ignored_o(ign),
    .wake_pull_select_field_o(wkp), .general_io_pull_select_o(iop),
    .slew_control_off_o(slew), .high_side_output_o(hs), .timer_running_o(run),
    .cycle_wake_o(cwk), .cycle_sense_o(csen));

  wtcr_host u_wtcr_host (.clk_sys_i(clk_sys_i), .serial_miso_i(miso),
    .serial_clk_o(sclk), .serial_select_n_o(serial_select_n), .serial_mosi_o(mosi));

  task automatic give_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_wtcr_host.xfer({1'h1, a, d}, 16, rx);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    u_wtcr_host.xfer({1'h0, a, 8'h00}, 16, rx);
    chk(rx[7:0], exp);
  endtask : rdc

  // one-cycle pulse: 0 fail-safe entry, 1 restart clear, 2 soft reset
  task automatic pulse(input int k);
    @(posedge clk_sys_i);
    fse <= (k == 0);
    rcl <= (k == 1);
    srst <= (k == 2);
    @(posedge clk_sys_i);
    fse <= 1'h0;
    rcl <= 1'h0;
    srst <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
  endtask : pulse

  // counts high cycles of the switch output and clocks from rise to rise
  task automatic measure(output int hi, output int per);
    hi = 0;
    while (hs !== 1'h0) @(posedge clk_sys_i);
    while (hs !== 1'h1) @(posedge clk_sys_i);
    while (hs === 1'h1) begin
      hi++;
      @(posedge clk_sys_i);
    end
    per = hi;
    while (hs !== 1'h1) begin
      per++;
      @(posedge clk_sys_i);
    end
  endtask : measure

  task automatic t_reset_and_rate();
    rdc(OFS_INT_WAKE, 8'h00);
    rdc(OFS_EXT_WAKE, 8'h01);
    rdc(OFS_PULL, 8'h00);
    rdc(OFS_TIMER, 8'h00);
    wr(OFS_BUS_RATE, 8'hFF);
    rdc(OFS_BUS_RATE, 8'h10);
    chk(slew, 1'h1);
    wr(OFS_BUS_RATE, 8'h00);
    chk(slew, 1'h0);
    u_wtcr_host.xfer({1'h1, OFS_BUS_RATE, 8'h10}, 15, rx);
    rdc(OFS_BUS_RATE, 8'h00);
    chk(rx[15:8], 8'h01);
    u_wtcr_host.xfer({1'h0, OFS_STATUS, 8'h00}, 16, rx);
    wr(7'h30, 8'hFF);
    rdc(7'h30, 8'h00);
    chk(rx[15:8], 8'h00);
    // bus mode control lives outside this bank: the write is taken by no register here
    wr(7'h04, 8'h01);
    rdc(7'h04, 8'h00);
    chk(oe, 1'h0);
  endtask : t_reset_and_rate

  task automatic t_pull();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_PULL, {c[1:0], 4'hF, c[1:0]});
      rdc(OFS_PULL, {c[1:0], 4'h0, c[1:0]});
      chk(wkp, c[1:0]);
      chk(iop, 2'h0);
      gwk <= 1'h1;
      repeat (2) @(posedge clk_sys_i);
      chk(iop, c[1:0]);
      gwk <= 1'h0;
    end
  endtask : t_pull

  task automatic t_sense();
    nrm <= 1'h1;
    wkl <= 1'h1;
    iol <= 1'h1;
    wr(OFS_EXT_WAKE, 8'hFF);
    rdc(OFS_EXT_WAKE, 8'hA1);
    chk({ign, meas, src}, 3'h6);
    chk({wklo, iolo}, 2'h0);
    fo <= 1'h1;
    pulse(0);
    chk(ign, 1'h0);
    rdc(OFS_EXT_WAKE, 8'hA1);
    chk(src, 1'h0);
    wr(OFS_EXT_WAKE, 8'h80);
    chk({wklo, iolo}, 2'h3);
    wr(OFS_EXT_WAKE, 8'hA0);
    rdc(OFS_EXT_WAKE, 8'h80);
    chk(rx[15:8], 8'h01);
    pulse(0);
    rdc(OFS_EXT_WAKE, 8'h81);
    chk(src, 1'h1);
    fo <= 1'h0;
    u_wtcr_host.xfer({1'h0, OFS_STATUS, 8'h00}, 16, rx);
  endtask : t_sense

  task automatic t_timer();
    int hi;
    int per;
    // the timer is assigned as wake source before any on-time is written
    wr(OFS_INT_WAKE, 8'hFF);
    rdc(OFS_INT_WAKE, 8'h40);
    for (int c = 1; c < 6; c++) begin
      wr(OFS_TIMER, {1'h1, c[2:0], 4'h2});
      chk(run, 1'h1);
      rdc(OFS_TIMER, {1'h0, c[2:0], 4'h2});
      measure(hi, per);
      chk(hi, on_tk[c] * TK);
      chk(per, 500 * TK);
    end
    csa <= 1'h1;
    wr(OFS_TIMER, 8'h10);
    while (cwk !== 1'h1) @(posedge clk_sys_i);
    chk(csen, 1'h1);
    @(posedge clk_sys_i);
    per = 1;
    while (cwk !== 1'h1) begin
      per++;
      @(posedge clk_sys_i);
    end
    chk(per, 100 * TK);
    chk(csen, 1'h1);
    wr(OFS_TIMER, 8'h60);
    chk({hs, run}, 2'h2);
    wr(OFS_TIMER, 8'h00);
    chk(hs, 1'h0);
    wr(OFS_TIMER, 8'h32);
    pulse(0);
    rdc(OFS_TIMER, 8'h32);
    pulse(1);
    rdc(OFS_TIMER, 8'h00);
    chk(run, 1'h0);
    wr(OFS_PULL, 8'h41);
    pulse(2);
    rdc(OFS_PULL, 8'h00);
  endtask : t_timer

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    {reset_n_i, srst, fo, fse, rcl, csa, gwk, nrm, wkl, iol} = 10'h000;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    repeat (2) @(posedge clk_sys_i);
    t_reset_and_rate();
    t_pull();
    t_sense();
    t_timer();
    give_verdict();
  end
endmodule : wtcr_regs_tb
